//--- verilog/tx_dma_defs.svh
// Purpose: Shared constants of the transmit descriptor DMA.
// Assumes: Descriptor is four dwords; lengths are in bytes.
// Notes: Definitions only.
`ifndef TX_DMA_DEFS_SVH
`define TX_DMA_DEFS_SVH
// ---------------------------------------------------------------
// Descriptor layout
// ---------------------------------------------------------------
`define DESC_LAST_IDX 2'h3
`define DW0_OWN_BIT 31
`define DW0_STAT_LSB 16
`define DW0_LEN_MSB 15
`define DW2_LEN_MSB 15
`define DW2_FRAG_BIT 16
`define DW2_LAST_BIT 17
`define DW2_IRQ_BIT 18
`define DW2_NOFCS_BIT 19
`define FRAG_CNT_MSB 5
// Status post only touches the upper half of dword 0
`define POST_BE 4'hc
// ---------------------------------------------------------------
// Misc values
// ---------------------------------------------------------------
`define WORD_BYTES 16'h0004
`define ADDR_STEP 32'h00000004
`define LFSR_SEED 32'h00000001
`define LFSR_TAPS 32'h80200003
`define FIFO_DEPTH 16
`define HOST_MEM_WORDS 256
`endif

//--- verilog/tx_dma_pkg.sv
// Purpose: Types of the transmit descriptor DMA.
// Assumes: Nothing.
// Notes: Constants live in tx_dma_defs.svh.
package tx_dma_pkg;
  // Engine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FETCH = 4'h1,
    ST_CHECK = 4'h2,
    ST_FRAGHDR = 4'h3,
    ST_FRAGENT = 4'h4,
    ST_COPY = 4'h5,
    ST_PAD = 4'h6,
    ST_POST = 4'h7,
    ST_NEXT = 4'h8,
    ST_HALT = 4'h9
  } dmaState_e;
endpackage : tx_dma_pkg

//--- verilog/tx_dma_if.sv
// Purpose: Link between the DMA engine and host memory/driver.
// Assumes: One clock; host answers a request with a one-cycle ack.
// Notes: dev modport is the engine, host modport the host side.
`timescale 1ns/1ns
interface tx_dma_if;
  logic memReq; // Request level, held until ack
  logic memWe; // 1 write, 0 read
  logic [31:0] memAddr; // Byte address
  logic [31:0] memWdata; // Write data
  logic [3:0] memBe; // Write byte enables
  logic memAck; // One-cycle answer
  logic [31:0] memRdata; // Read data, valid with ack
  logic busError; // Fatal bus error pulse
  logic goSet; // Set tx_queue_go pulse
  logic ptrLoad; // Load descriptor pointer pulse
  logic [31:0] ptrValue; // First descriptor address
  logic earlyEn; // Early transmit enable
  logic [15:0] earlyThresh; // Early transmit threshold, bytes
  logic txQueueGo; // tx_queue_go level
  logic queueEmptyIrq; // Queue empty pulse
  logic chainDoneIrq; // Chain done pulse
  logic frameDoneIrq; // Frame done pulse
  logic busErrIrq; // Bus error pulse
  logic dmaIdle; // Engine idle level
  modport dev (
    output memReq, memWe, memAddr, memWdata, memBe,
    input memAck, memRdata, busError,
    input goSet, ptrLoad, ptrValue, earlyEn, earlyThresh,
    output txQueueGo, queueEmptyIrq, chainDoneIrq, frameDoneIrq,
    output busErrIrq, dmaIdle
  );
  modport host (
    input memReq, memWe, memAddr, memWdata, memBe,
    output memAck, memRdata, busError,
    output goSet, ptrLoad, ptrValue, earlyEn, earlyThresh,
    input txQueueGo, queueEmptyIrq, chainDoneIrq, frameDoneIrq,
    input busErrIrq, dmaIdle
  );
endinterface : tx_dma_if

//--- verilog/tx_dma_device.sv
// Purpose: Transmit descriptor DMA engine and its data FIFO.
// Assumes: Host acks each request; transmitter drains the FIFO.
// Notes: FIFO module first, engine after it.
`timescale 1ns/1ns
`include "tx_dma_defs.svh"

// ---------------------------------------------------------------
// Data FIFO
// ---------------------------------------------------------------
module tx_fifo #(
  parameter int Width = 32,
  parameter int Depth = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [Width-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [Width-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(Depth);
  typedef struct packed {
    logic [Depth-1:0][Width-1:0] mem; // Storage
    logic [AW:0] wp; // Write pointer, wrap bit on top
    logic [AW:0] rp; // Read pointer
  } fifo_s;
  fifo_s cur_ff, nxt_ff;
  logic doPush, doPop;

  // Flags from pointer distance
  assign inReady = (cur_ff.wp - cur_ff.rp) != (AW + 1)'(Depth);
  assign outValid = cur_ff.wp != cur_ff.rp;
  assign outData = cur_ff.mem[cur_ff.rp[AW-1:0]];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // Pointer and storage update
  always_comb begin
    nxt_ff = cur_ff;
    if (doPush) begin
      nxt_ff.mem[cur_ff.wp[AW-1:0]] = inData;
      nxt_ff.wp = cur_ff.wp + 1'b1;
    end
    if (doPop) begin
      nxt_ff.rp = cur_ff.rp + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
endmodule : tx_fifo

// ---------------------------------------------------------------
// Engine
// ---------------------------------------------------------------
module tx_dma_device #(
  parameter int FifoDepth = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  tx_dma_if.dev bus,
  output logic [31:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic txStart,
  output logic [15:0] txLen,
  output logic txSkipFcs,
  input wire logic txDone,
  input wire logic [14:0] txStatus
);
  typedef struct packed {
    tx_dma_pkg::dmaState_e st; // Engine state
    tx_dma_pkg::dmaState_e ret; // State to resume after a post
    logic go; // tx_queue_go
    logic [31:0] curPtr; // Current descriptor pointer
    logic [1:0] idx; // Dword index within a fetch
    logic [3:0][31:0] dw; // Fetched descriptor
    logic fragMode; // Frame uses a fragment list
    logic [31:0] fragPtr; // Next fragment list entry
    logic [5:0] fragLeft; // Fragments still to copy
    logic [31:0] bufPtr; // Buffer read address
    logic [14:0] bufWords; // Words left in this buffer or pad
    logic [15:0] remain; // Remaining transmit byte count
    logic [15:0] frameLen; // Length of frame being copied
    logic inFrame; // Copy of a frame is under way
    logic copyDone; // Frame fully loaded
    logic startedCur; // Frame being copied has been started
    logic [15:0] loaded; // Bytes of this frame in the buffer
    logic [31:0] copyDesc; // First descriptor of copied frame
    logic copyIrq; // Its frame done request
    logic copyNoFcs; // Its skip FCS request
    logic txBusy; // Transmitter is sending
    logic [31:0] txDesc; // First descriptor of sent frame
    logic txIrq; // Frame done request of sent frame
    logic postPend; // Status waiting to be posted
    logic [31:0] postAddr; // Where to post
    logic [14:0] postStat; // What to post
    logic postIrq; // Raise frame done after post
    logic chainPend; // A frame went out since last chain done
    logic [31:0] lfsr; // Pad data source
    logic start; // txStart pulse
    logic [15:0] len; // txLen
    logic noFcs; // txSkipFcs
    logic qEmpty; // Queue empty pulse
    logic chainDone; // Chain done pulse
    logic frameDone; // Frame done pulse
    logic busErr; // Bus error pulse
  } dev_s;
  dev_s cur_ff, nxt_ff;
  logic pushValid, pushReady;
  logic [31:0] pushData;
  logic startOk;

  // Words needed to hold a byte count
  function automatic logic [14:0] words4(input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, b} + 17'h00003;
    return s[16:2];
  endfunction : words4

  // Lesser of remaining count and a buffer length
  function automatic logic [15:0] min16(input logic [15:0] a,
                                        input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction : min16

  // Memory request decode per state
  always_comb begin
    bus.memReq = 1'b0;
    bus.memWe = 1'b0;
    bus.memAddr = cur_ff.curPtr + {28'h0000000, cur_ff.idx, 2'b00};
    bus.memWdata = {1'b0, cur_ff.postStat, 16'h0000};
    bus.memBe = `POST_BE;
    case (cur_ff.st)
      tx_dma_pkg::ST_FETCH: begin
        bus.memReq = 1'b1;
      end
      tx_dma_pkg::ST_FRAGHDR, tx_dma_pkg::ST_FRAGENT: begin
        bus.memReq = (cur_ff.st == tx_dma_pkg::ST_FRAGHDR) ||
                     (cur_ff.fragLeft != 6'h00);
        bus.memAddr = cur_ff.fragPtr;
      end
      tx_dma_pkg::ST_COPY: begin
        bus.memReq = (cur_ff.bufWords != 15'h0000) && pushReady;
        bus.memAddr = cur_ff.bufPtr;
      end
      tx_dma_pkg::ST_POST: begin
        bus.memReq = 1'b1;
        bus.memWe = 1'b1;
        bus.memAddr = cur_ff.postAddr;
      end
      default: begin
        bus.memReq = 1'b0;
      end
    endcase
  end

  // FIFO fill: buffer words or pad words
  assign pushValid = (cur_ff.st == tx_dma_pkg::ST_COPY && bus.memAck &&
                      cur_ff.bufWords != 15'h0000) ||
                     (cur_ff.st == tx_dma_pkg::ST_PAD &&
                      cur_ff.bufWords != 15'h0000);
  assign pushData = (cur_ff.st == tx_dma_pkg::ST_PAD) ? cur_ff.lfsr
                                                      : bus.memRdata;
  // Start when loaded and transmitter free
  assign startOk = !cur_ff.startedCur && !cur_ff.txBusy &&
                   !cur_ff.postPend && cur_ff.st != tx_dma_pkg::ST_HALT &&
                   (cur_ff.copyDone || (bus.earlyEn && cur_ff.inFrame &&
                    cur_ff.loaded >= bus.earlyThresh));

  tx_fifo #(.Width(32), .Depth(FifoDepth)) dataFifo (
    .clk(clk),
    .rst(rst),
    .inData(pushData),
    .inValid(pushValid),
    .inReady(pushReady),
    .outData(txData),
    .outValid(txValid),
    .outReady(txReady)
  );

  // Next state
  always_comb begin
    logic [15:0] rem;
    logic [15:0] cnt;
    logic fin;
    rem = cur_ff.inFrame ? cur_ff.remain : cur_ff.dw[0][`DW0_LEN_MSB:0];
    cnt = min16(rem, cur_ff.dw[2][`DW2_LEN_MSB:0]);
    fin = (cur_ff.remain == 16'h0000) || (cur_ff.fragMode ?
          cur_ff.fragLeft == 6'h00 : cur_ff.dw[2][`DW2_LAST_BIT]);
    nxt_ff = cur_ff;
    nxt_ff.start = 1'b0;
    nxt_ff.qEmpty = 1'b0;
    nxt_ff.chainDone = 1'b0;
    nxt_ff.frameDone = 1'b0;
    nxt_ff.busErr = 1'b0;
    case (cur_ff.st)
      tx_dma_pkg::ST_IDLE: begin
        if (cur_ff.postPend) begin
          nxt_ff.ret = tx_dma_pkg::ST_IDLE;
          nxt_ff.st = tx_dma_pkg::ST_POST;
        end else if (cur_ff.go) begin
          nxt_ff.idx = 2'h0;
          nxt_ff.st = tx_dma_pkg::ST_FETCH;
        end else if (cur_ff.chainPend && !cur_ff.txBusy &&
                     !cur_ff.inFrame) begin
          nxt_ff.chainPend = 1'b0;
          nxt_ff.chainDone = 1'b1;
        end
      end
      tx_dma_pkg::ST_FETCH: begin
        if (bus.memAck) begin
          nxt_ff.dw[cur_ff.idx] = bus.memRdata;
          nxt_ff.idx = cur_ff.idx + 2'h1;
          if (cur_ff.idx == `DESC_LAST_IDX) begin
            nxt_ff.st = tx_dma_pkg::ST_CHECK;
          end
        end
      end
      tx_dma_pkg::ST_CHECK: begin
        if (!cur_ff.dw[0][`DW0_OWN_BIT]) begin
          nxt_ff.go = 1'b0;
          nxt_ff.qEmpty = 1'b1;
          nxt_ff.st = tx_dma_pkg::ST_IDLE;
        end else begin
          nxt_ff.curPtr = cur_ff.dw[3];
          if (!cur_ff.inFrame) begin
            nxt_ff.inFrame = 1'b1;
            nxt_ff.frameLen = cur_ff.dw[0][`DW0_LEN_MSB:0];
            nxt_ff.copyDesc = cur_ff.curPtr;
            nxt_ff.copyDone = 1'b0;
            nxt_ff.startedCur = 1'b0;
            nxt_ff.loaded = 16'h0000;
          end
          nxt_ff.remain = rem;
          nxt_ff.fragMode = cur_ff.dw[2][`DW2_FRAG_BIT];
          if (cur_ff.dw[2][`DW2_FRAG_BIT]) begin
            nxt_ff.fragPtr = cur_ff.dw[1];
            nxt_ff.st = tx_dma_pkg::ST_FRAGHDR;
          end else begin
            nxt_ff.bufPtr = cur_ff.dw[1];
            nxt_ff.bufWords = words4(cnt);
            nxt_ff.remain = rem - cnt;
            nxt_ff.st = tx_dma_pkg::ST_COPY;
          end
        end
      end
      tx_dma_pkg::ST_FRAGHDR: begin
        if (bus.memAck) begin
          nxt_ff.fragLeft = bus.memRdata[`FRAG_CNT_MSB:0];
          nxt_ff.fragPtr = cur_ff.fragPtr + `ADDR_STEP;
          nxt_ff.idx = 2'h0;
          nxt_ff.st = tx_dma_pkg::ST_FRAGENT;
        end
      end
      tx_dma_pkg::ST_FRAGENT: begin
        if (cur_ff.fragLeft == 6'h00) begin
          nxt_ff.bufWords = 15'h0000;
          nxt_ff.st = tx_dma_pkg::ST_COPY;
        end else if (bus.memAck) begin
          nxt_ff.fragPtr = cur_ff.fragPtr + `ADDR_STEP;
          if (cur_ff.idx == 2'h0) begin
            nxt_ff.bufPtr = bus.memRdata;
            nxt_ff.idx = 2'h1;
          end else begin
            cnt = min16(cur_ff.remain, bus.memRdata[15:0]);
            nxt_ff.bufWords = words4(cnt);
            nxt_ff.remain = cur_ff.remain - cnt;
            nxt_ff.fragLeft = cur_ff.fragLeft - 6'h01;
            nxt_ff.st = tx_dma_pkg::ST_COPY;
          end
        end
      end
      tx_dma_pkg::ST_COPY: begin
        if (cur_ff.bufWords != 15'h0000) begin
          if (bus.memAck) begin
            nxt_ff.bufPtr = cur_ff.bufPtr + `ADDR_STEP;
            nxt_ff.bufWords = cur_ff.bufWords - 15'h0001;
            nxt_ff.loaded = cur_ff.loaded + `WORD_BYTES;
          end
        end else if (cur_ff.postPend) begin
          nxt_ff.ret = tx_dma_pkg::ST_COPY;
          nxt_ff.st = tx_dma_pkg::ST_POST;
        end else if (fin) begin
          nxt_ff.copyIrq = cur_ff.dw[2][`DW2_IRQ_BIT];
          nxt_ff.copyNoFcs = cur_ff.dw[2][`DW2_NOFCS_BIT];
          if (cur_ff.startedCur) begin
            nxt_ff.txIrq = cur_ff.dw[2][`DW2_IRQ_BIT];
            nxt_ff.noFcs = cur_ff.dw[2][`DW2_NOFCS_BIT];
          end
          nxt_ff.bufWords = words4(cur_ff.remain);
          nxt_ff.remain = 16'h0000;
          nxt_ff.st = tx_dma_pkg::ST_PAD;
        end else begin
          nxt_ff.idx = 2'h0;
          nxt_ff.st = cur_ff.fragMode ? tx_dma_pkg::ST_FRAGENT
                                      : tx_dma_pkg::ST_FETCH;
        end
      end
      tx_dma_pkg::ST_PAD: begin
        if (cur_ff.bufWords == 15'h0000) begin
          nxt_ff.inFrame = 1'b0;
          nxt_ff.copyDone = 1'b1;
          nxt_ff.st = tx_dma_pkg::ST_NEXT;
        end else if (pushReady) begin
          nxt_ff.lfsr = {cur_ff.lfsr[30:0], ^(cur_ff.lfsr & `LFSR_TAPS)};
          nxt_ff.bufWords = cur_ff.bufWords - 15'h0001;
          nxt_ff.loaded = cur_ff.loaded + `WORD_BYTES;
        end
      end
      tx_dma_pkg::ST_NEXT: begin
        if (cur_ff.postPend) begin
          nxt_ff.ret = tx_dma_pkg::ST_NEXT;
          nxt_ff.st = tx_dma_pkg::ST_POST;
        end else if (cur_ff.startedCur) begin
          nxt_ff.idx = 2'h0;
          nxt_ff.st = cur_ff.go ? tx_dma_pkg::ST_FETCH
                                : tx_dma_pkg::ST_IDLE;
        end
      end
      tx_dma_pkg::ST_POST: begin
        if (bus.memAck) begin
          nxt_ff.postPend = 1'b0;
          nxt_ff.frameDone = cur_ff.postIrq;
          nxt_ff.st = cur_ff.ret;
        end
      end
      default: begin
        nxt_ff.st = tx_dma_pkg::ST_HALT;
      end
    endcase
    // Transmitter finished: queue the status post
    if (txDone && cur_ff.txBusy) begin
      nxt_ff.txBusy = 1'b0;
      nxt_ff.postPend = 1'b1;
      nxt_ff.postAddr = cur_ff.txDesc;
      nxt_ff.postStat = txStatus;
      nxt_ff.postIrq = cur_ff.txIrq;
    end
    // Launch the frame being copied
    if (startOk) begin
      nxt_ff.start = 1'b1;
      nxt_ff.startedCur = 1'b1;
      nxt_ff.txBusy = 1'b1;
      nxt_ff.chainPend = 1'b1;
      nxt_ff.len = cur_ff.frameLen;
      nxt_ff.txDesc = cur_ff.copyDesc;
      // Flags of a copy that ends this very cycle count as well
      nxt_ff.txIrq = nxt_ff.copyIrq;
      nxt_ff.noFcs = nxt_ff.copyNoFcs;
    end
    // Driver commands; set wins over the engine's clear
    if (bus.ptrLoad) begin
      nxt_ff.curPtr = bus.ptrValue;
    end
    if (bus.goSet) begin
      nxt_ff.go = 1'b1;
    end
    // Fatal bus error halts the engine and cancels a start pulse; the FIFO still drains to the transmitter
    if (bus.busError && cur_ff.st != tx_dma_pkg::ST_HALT) begin
      nxt_ff.st = tx_dma_pkg::ST_HALT;
      nxt_ff.busErr = 1'b1;
      nxt_ff.start = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.startedCur <= 1'b1;
      cur_ff.lfsr <= `LFSR_SEED;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs
  assign txStart = cur_ff.start;
  assign txLen = cur_ff.len;
  assign txSkipFcs = cur_ff.noFcs;
  assign bus.txQueueGo = cur_ff.go;
  assign bus.queueEmptyIrq = cur_ff.qEmpty;
  assign bus.chainDoneIrq = cur_ff.chainDone;
  assign bus.frameDoneIrq = cur_ff.frameDone;
  assign bus.busErrIrq = cur_ff.busErr;
  assign bus.dmaIdle = cur_ff.st == tx_dma_pkg::ST_IDLE &&
                       !cur_ff.inFrame && !cur_ff.txBusy;
endmodule : tx_dma_device

//--- verilog/tx_dma_host.sv
// Purpose: Host end: descriptor memory and driver command port.
// Assumes: Driver builds descriptors through the sw port.
// Notes: Addresses beyond the memory give a fatal bus error.
`timescale 1ns/1ns
`include "tx_dma_defs.svh"

// ---------------------------------------------------------------
// Host memory and command relay
// ---------------------------------------------------------------
module tx_dma_host #(
  parameter int MemWords = `HOST_MEM_WORDS
) (
  input wire logic clk,
  input wire logic rst,
  tx_dma_if.host bus,
  input wire logic swWe,
  input wire logic [$clog2(MemWords)-1:0] swAddr,
  input wire logic [31:0] swWdata,
  output logic [31:0] swRdata,
  input wire logic swGo,
  input wire logic swPtrLoad,
  input wire logic [31:0] swPtr,
  input wire logic swEarlyEn,
  input wire logic [15:0] swEarlyThresh,
  output logic txQueueGo,
  output logic queueEmptyIrq,
  output logic chainDoneIrq,
  output logic frameDoneIrq,
  output logic busErrIrq,
  output logic dmaIdle
);
  localparam int AW = $clog2(MemWords);
  typedef struct packed {
    logic [MemWords-1:0][31:0] mem; // Host memory words
    logic ack; // Answer pulse
    logic [31:0] rdata; // Read answer
    logic busErr; // Master abort pulse
    logic go; // Go pulse to engine
    logic ptrLoad; // Pointer load pulse
    logic [31:0] ptr; // Pointer value
    logic earlyEn; // Early transmit enable
    logic [15:0] thresh; // Early threshold
    logic [31:0] swRd; // Driver read data
  } host_s;
  host_s cur_ff, nxt_ff;

  // Memory, answers and command relay
  always_comb begin
    logic [29:0] wIdx;
    wIdx = bus.memAddr[31:2];
    nxt_ff = cur_ff;
    nxt_ff.ack = 1'b0;
    nxt_ff.busErr = 1'b0;
    // Driver writes chain before go
    if (swWe) begin
      nxt_ff.mem[swAddr] = swWdata;
    end
    nxt_ff.swRd = cur_ff.mem[swAddr];
    // One answer per request, every other cycle at most
    if (bus.memReq && !cur_ff.ack && !cur_ff.busErr) begin
      if (wIdx >= 30'(MemWords)) begin
        nxt_ff.busErr = 1'b1;
      end else begin
        nxt_ff.ack = 1'b1;
        nxt_ff.rdata = cur_ff.mem[wIdx[AW-1:0]];
        if (bus.memWe) begin
          for (int b = 0; b < 4; b++) begin
            if (bus.memBe[b]) begin
              nxt_ff.mem[wIdx[AW-1:0]][b*8 +: 8] = bus.memWdata[b*8 +: 8];
            end
          end
        end
      end
    end
    nxt_ff.go = swGo;
    nxt_ff.ptrLoad = swPtrLoad;
    nxt_ff.ptr = swPtr;
    nxt_ff.earlyEn = swEarlyEn;
    nxt_ff.thresh = swEarlyThresh;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs
  assign bus.memAck = cur_ff.ack;
  assign bus.memRdata = cur_ff.rdata;
  assign bus.busError = cur_ff.busErr;
  assign bus.goSet = cur_ff.go;
  assign bus.ptrLoad = cur_ff.ptrLoad;
  assign bus.ptrValue = cur_ff.ptr;
  assign bus.earlyEn = cur_ff.earlyEn;
  assign bus.earlyThresh = cur_ff.thresh;
  assign swRdata = cur_ff.swRd;
  assign txQueueGo = bus.txQueueGo;
  assign queueEmptyIrq = bus.queueEmptyIrq;
  assign chainDoneIrq = bus.chainDoneIrq;
  assign frameDoneIrq = bus.frameDoneIrq;
  assign busErrIrq = bus.busErrIrq;
  assign dmaIdle = bus.dmaIdle;
endmodule : tx_dma_host

//--- tb/tx_dma_chk.sv
// Purpose: Bus and event checks on the DMA link.
// Assumes: One clock, synchronous reset.
// Notes: Sees the interface signals only.
`timescale 1ns/1ns
module tx_dma_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic [3:0] memBe,
  input wire logic memAck,
  input wire logic busError,
  input wire logic goSet,
  input wire logic txQueueGo,
  input wire logic queueEmptyIrq,
  input wire logic chainDoneIrq,
  input wire logic frameDoneIrq,
  input wire logic busErrIrq,
  input wire logic dmaIdle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic emptyFf; // Queue empty seen since last chain end
  logic haltFf; // Bus error seen
  // Event history for ordering checks
  always_ff @(posedge clk) begin
    emptyFf <= ~rst & (queueEmptyIrq | emptyFf) & ~chainDoneIrq;
    haltFf <= ~rst & (haltFf | busErrIrq);
  end
  a_req_held: assert property (
    memReq && !memAck && !busError |=> memReq && $stable(memAddr))
    else $error("request dropped before answer");
  a_ack_single: assert property (
    memAck |=> !memAck) else $error("answer longer than one cycle");
  a_post_fields: assert property (
    memReq && memWe |-> !memWdata[31] && memBe == 4'hc)
    else $error("status post keeps ownership or length");
  a_empty_go: assert property (
    queueEmptyIrq && !$past(goSet) |-> !txQueueGo)
    else $error("go left set at queue empty");
  a_chain_order: assert property (
    chainDoneIrq |-> emptyFf) else $error("chain done before queue empty");
  a_go_fetch: assert property (
    goSet && dmaIdle && !haltFf |-> ##[1:12] memReq && !memWe)
    else $error("no descriptor fetch after go");
  a_halt_quiet: assert property (
    busError |=> !memReq [*8]) else $error("requests after bus error");
  a_err_flag: assert property (
    busError |=> ##[0:1] busErrIrq) else $error("bus error event missing");
  a_done_ack: assert property (
    frameDoneIrq |-> $past(memAck) && $past(memWe))
    else $error("frame done without acked post");
endmodule : tx_dma_chk

//--- tb/tx_descriptor_dma_tb.sv
// Purpose: Self-checking bench of the transmit descriptor DMA.
// Assumes: Host memory of 256 words, early transmit at 8 bytes.
// Notes: Three frames, queue end, requeue, bus error.
`timescale 1ns/1ns
module tx_descriptor_dma_tb;
  logic clk = 1'b0, rst = 1'b1, swWe = 1'b0, swGo = 1'b0;
  logic swPtrLoad = 1'b0, txReady = 1'b0, txDone = 1'b0;
  logic txValid, txStart, txSkipFcs;
  logic [7:0] swAddr = 8'h00;
  logic [31:0] swWdata = 32'h0, swPtr = 32'h0, swRdata, txData;
  logic [15:0] txLen;
  logic [14:0] txStatus = 15'h0;
  logic swEarlyEn = 1'b0; // Early transmit, set with the pointer
  logic [15:0] swEarlyThresh = 16'h0008; // Early threshold, bytes
  logic [32:0] wordQ[$], w; // Expected words, bit 32 marks pad
  logic [16:0] frameQ[$]; // Expected skip flag and length
  int errTotal = 0, checksDone = 0, txCnt = 0;
  int nEmpty = 0, nChain = 0, nFrame = 0, nErr = 0;
  always #25 clk = ~clk;
  tx_dma_if bus();
  tx_dma_device i_tx_dma_device (.clk(clk), .rst(rst), .bus(bus.dev),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .txStart(txStart), .txLen(txLen), .txSkipFcs(txSkipFcs),
    .txDone(txDone), .txStatus(txStatus));
  tx_dma_host i_tx_dma_host (.clk(clk), .rst(rst), .bus(bus.host),
    .swWe(swWe), .swAddr(swAddr), .swWdata(swWdata), .swRdata(swRdata),
    .swGo(swGo), .swPtrLoad(swPtrLoad), .swPtr(swPtr), .swEarlyEn(swEarlyEn),
    .swEarlyThresh(swEarlyThresh), .txQueueGo(), .queueEmptyIrq(),
    .chainDoneIrq(), .frameDoneIrq(), .busErrIrq(), .dmaIdle());
  tx_dma_chk i_tx_dma_chk (.clk(clk), .rst(rst), .memReq(bus.memReq),
    .memWe(bus.memWe), .memAddr(bus.memAddr), .memWdata(bus.memWdata),
    .memBe(bus.memBe), .memAck(bus.memAck), .busError(bus.busError),
    .goSet(bus.goSet), .txQueueGo(bus.txQueueGo),
    .queueEmptyIrq(bus.queueEmptyIrq), .chainDoneIrq(bus.chainDoneIrq),
    .frameDoneIrq(bus.frameDoneIrq), .busErrIrq(bus.busErrIrq),
    .dmaIdle(bus.dmaIdle));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checksDone++;
    if (e !== g) begin
      errTotal++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    swWe <= 1'b1;
    swAddr <= a;
    swWdata <= d;
    @(posedge clk);
  endtask : wr
  task automatic desc(logic [7:0] a, logic [31:0] d0, d1, d2, d3);
    wr(a, d0);
    wr(a + 8'h01, d1);
    wr(a + 8'h02, d2);
    wr(a + 8'h03, d3);
  endtask : desc
  task automatic rnd(logic [7:0] a);
    logic [31:0] d;
    d = $urandom;
    wr(a, d);
    wordQ.push_back({1'b0, d});
  endtask : rnd
  task automatic rd(logic [7:0] a, logic [16:0] e);
    swAddr <= a;
    repeat (2) @(posedge clk);
    chk("posted status", e, {swRdata[31], swRdata[15:0]});
  endtask : rd
  task automatic waitCnt(ref int c, input int n);
    for (int i = 0; i < 3000 && c < n; i++) @(posedge clk);
    chk("event count", n, c);
  endtask : waitCnt
  task automatic tallyAndFinish();
    $display("Checks %0d, errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tallyAndFinish
  // Transmitter model, event counters and FIFO word compare
  always @(posedge clk) begin
    txReady <= 1'($urandom);
    if (bus.queueEmptyIrq === 1'b1) nEmpty++;
    if (bus.chainDoneIrq === 1'b1) nChain++;
    if (bus.frameDoneIrq === 1'b1) nFrame++;
    if (bus.busErrIrq === 1'b1) nErr++;
    if (txValid === 1'b1 && txReady === 1'b1) begin
      w = (wordQ.size() > 0) ? wordQ.pop_front() : 33'h000000000;
      if (!w[32]) chk("fifo word", w[31:0], txData);
    end
    if (txStart === 1'b1) txCnt = 40;
    else if (txCnt > 0) txCnt--;
    // One assignment per edge: done pulse in the last cycle of a frame
    txDone <= (txCnt == 1);
    if (txCnt == 1) begin
      txStatus <= 15'($urandom);
      chk("len and skip", frameQ.pop_front(), {txSkipFcs, txLen});
    end
  end
  initial begin
    void'($urandom(41));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    desc(8'h00, 32'h80000008, 32'h00000100, 32'h00020008,
      32'h00000010);
    desc(8'h04, 32'h8000000c, 32'h00000120, 32'h00000004,
      32'h00000020);
    desc(8'h08, 32'h80000000, 32'h00000140, 32'h000e0010,
      32'h00000030);
    desc(8'h0c, 32'h8000000c, 32'h00000160, 32'h00020004,
      32'h00000040);
    rnd(8'h40);
    rnd(8'h41);
    rnd(8'h48);
    rnd(8'h50);
    rnd(8'h51);
    rnd(8'h58);
    wordQ.push_back(33'h100000000);
    wordQ.push_back(33'h100000000);
    frameQ = '{17'h00008, 17'h1000c, 17'h0000c};
    swWe <= 1'b0;
    swEarlyEn <= 1'b1;
    swPtrLoad <= 1'b1;
    @(posedge clk);
    swPtrLoad <= 1'b0;
    swGo <= 1'b1;
    @(posedge clk);
    swGo <= 1'b0;
    waitCnt(nChain, 1);
    chk("queue empty", 1, nEmpty);
    chk("frame done", 1, nFrame);
    chk("words left", 0, wordQ.size());
    chk("frames left", 0, frameQ.size());
    rd(8'h00, 17'h00008);
    rd(8'h04, 17'h0000c);
    rd(8'h0c, 17'h0000c);
    swGo <= 1'b1;
    @(posedge clk);
    swGo <= 1'b0;
    for (int i = 0; i < 50 && bus.memReq !== 1'b1; i++) @(posedge clk);
    chk("requeue address", 32'h00000040, bus.memAddr);
    waitCnt(nEmpty, 2);
    swPtr <= 32'h00000400;
    swPtrLoad <= 1'b1;
    @(posedge clk);
    swPtrLoad <= 1'b0;
    swGo <= 1'b1;
    @(posedge clk);
    swGo <= 1'b0;
    waitCnt(nErr, 1);
    repeat (20) @(posedge clk);
    chk("chain done", 1, nChain);
    tallyAndFinish();
  end
  // Watchdog against a hang
  initial begin
    #500000;
    errTotal++;
    tallyAndFinish();
  end
endmodule : tx_descriptor_dma_tb
